//--- core/ldcfg_bank.sv
/*
  led driver dimming configuration bank: ahb-lite slave holding the three
  configuration bytes plus an auxiliary and a status word, with decoded
  fields, fault gating, transistor choice and dither gating.
  assumes fault flags, current setting and slope flag come from logic on
  hclk; the pwm input arrives from a pin.
*/
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module ldcfg_bank
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [3:0]            cluster_string,
  input  wire logic [3:0]            open_fault_raw,
  input  wire logic [3:0]            short_fault_raw,
  input  wire logic [11:0]           current_setting,
  input  wire logic                  brightness_sloping,
  input  wire logic                  pwm_in_pin,
  output ldcfg_pkg::ldcfg_decoded_t  cfg,
  output logic [3:0]                 open_fault_report,
  output logic [3:0]                 short_fault_report,
  output logic                       small_transistor_active,
  output logic [2:0]                 dither_depth_active,
  output logic                       pwm_pass_out
);

  // ---------------------------------------------------------------
  // bus address phase capture
  // ---------------------------------------------------------------
  logic        wr_pend_q;       // write data phase in progress
  logic        wr_pend_d;
  logic [11:0] wr_addr_q;       // byte address of pending write
  logic [11:0] wr_addr_d;
  logic        rd_take;         // read taken in this address phase

  // only single whole-word transfers reach us; size is not checked
  assign rd_take = hsel && htrans[1] && hready && !hwrite;

  // next values of the address phase latch
  always_comb
  begin
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    if (hready)
    begin
      wr_pend_d = hsel && htrans[1] && hwrite;
      wr_addr_d = haddr[11:0];
    end
  end

  // register the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // ---------------------------------------------------------------
  // configuration storage
  // ---------------------------------------------------------------
  logic [7:0] fault_and_headroom_config_q;
  logic [7:0] fault_and_headroom_config_d;
  logic [7:0] dimming_resolution_config_q;
  logic [7:0] dimming_resolution_config_d;
  logic [7:0] brightness_source_config_q;
  logic [7:0] brightness_source_config_d;
  logic [7:0] aux_config_q;     // max_current_scale and steady dither
  logic [7:0] aux_config_d;

  // write in the data phase; the byte sits in the low lane
  always_comb
  begin
    fault_and_headroom_config_d = fault_and_headroom_config_q;
    dimming_resolution_config_d = dimming_resolution_config_q;
    brightness_source_config_d  = brightness_source_config_q;
    aux_config_d                = aux_config_q;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        {2'b00, ldcfg_pkg::LDCFG_IDX_FAULT, 2'b00}:
          fault_and_headroom_config_d = hwdata[7:0];
        {2'b00, ldcfg_pkg::LDCFG_IDX_DIM, 2'b00}:
          dimming_resolution_config_d = hwdata[7:0];
        {2'b00, ldcfg_pkg::LDCFG_IDX_BRT, 2'b00}:
          // reserved bit is never stored, so it cannot steer anything
          brightness_source_config_d = {1'b0, hwdata[6:0]};
        ldcfg_pkg::LDCFG_ADDR_AUX:
          aux_config_d = {4'h0, hwdata[3:0]};
        default:
          ;  // unmapped or read-only: write ignored, answer stays okay
      endcase
    end
  end

  // storage flops; no documented reset value, plain zero defaults
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fault_and_headroom_config_q <= ldcfg_pkg::LDCFG_RST_FAULT;
      dimming_resolution_config_q <= ldcfg_pkg::LDCFG_RST_DIM;
      brightness_source_config_q  <= ldcfg_pkg::LDCFG_RST_BRT;
      aux_config_q                <= ldcfg_pkg::LDCFG_RST_AUX;
    end
    else
    begin
      fault_and_headroom_config_q <= fault_and_headroom_config_d;
      dimming_resolution_config_q <= dimming_resolution_config_d;
      brightness_source_config_q  <= brightness_source_config_d;
      aux_config_q                <= aux_config_d;
    end
  end

  // ---------------------------------------------------------------
  // pwm input pin synchroniser
  // ---------------------------------------------------------------
  logic pwm_meta_q;   // first stage, read only by the second
  logic pwm_sync_q;

  // two flops before the pin is used anywhere
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwm_meta_q <= 1'b0;
      pwm_sync_q <= 1'b0;
    end
    else
    begin
      pwm_meta_q <= pwm_in_pin;
      pwm_sync_q <= pwm_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // decode and derived controls
  // ---------------------------------------------------------------
  ldcfg_pkg::ldcfg_decoded_t cfg_d;
  logic [3:0]                open_report_d;
  logic [3:0]                short_report_d;
  logic                      small_fet_d;
  logic [2:0]                dither_act_d;
  logic                      pwm_pass_d;
  logic [2:0]                dither_code;
  logic [2:0]                scale_code;
  logic [3:0]                report_gate;

  // decode from the next-state bytes so outputs follow a write at once
  always_comb
  begin
    dither_code = dimming_resolution_config_d[ldcfg_pkg::LDCFG_DITHER_LSB +: 3];
    scale_code  = aux_config_d[ldcfg_pkg::LDCFG_SCALE_LSB +: 3];
    cfg_d.cluster_fault_enable =
      fault_and_headroom_config_d[ldcfg_pkg::LDCFG_CL_FAULT_BIT];
    cfg_d.gap_mv = ldcfg_pkg::LDCFG_GAP_MV[
      fault_and_headroom_config_d[ldcfg_pkg::LDCFG_GAP_LSB +: 2]];
    cfg_d.short_level_dv = ldcfg_pkg::LDCFG_SHORT_DV[
      fault_and_headroom_config_d[ldcfg_pkg::LDCFG_SHORT_LSB +: 2]];
    cfg_d.headroom_mv = ldcfg_pkg::LDCFG_HEAD_MV[
      fault_and_headroom_config_d[ldcfg_pkg::LDCFG_HEAD_LSB +: 3]];
    cfg_d.slope_gain_milli = ldcfg_pkg::LDCFG_SLOPE_MILLI[
      dimming_resolution_config_d[ldcfg_pkg::LDCFG_SLOPE_LSB +: 3]];
    // only meaningful while the generator runs from the internal oscillator
    cfg_d.pwm_clock_mhz = ldcfg_pkg::LDCFG_PWM_MHZ[
      dimming_resolution_config_d[ldcfg_pkg::LDCFG_RES_LSB +: 2]];
    // top bit set means four bits, lower bits ignored
    cfg_d.dither_depth = dither_code[2] ? 3'd4 : {1'b0, dither_code[1:0]};
    cfg_d.switch_permille = ldcfg_pkg::LDCFG_SWITCH_PERMILLE[
      brightness_source_config_d[ldcfg_pkg::LDCFG_SWITCH_LSB +: 3]];
    cfg_d.external_set_resistor_enable =
      brightness_source_config_d[ldcfg_pkg::LDCFG_EXT_SET_BIT];
    // stored scale applies only while the set resistor is off
    cfg_d.max_current_ma = cfg_d.external_set_resistor_enable ? 8'h00 :
      ldcfg_pkg::LDCFG_CUR_MA[scale_code];
    cfg_d.brightness_source_select = ldcfg_pkg::ldcfg_brt_t'(
      brightness_source_config_d[ldcfg_pkg::LDCFG_BRT_LSB +: 2]);

    // display strings always report; cluster strings only when enabled
    report_gate    = ~cluster_string | {4{cfg_d.cluster_fault_enable}};
    open_report_d  = open_fault_raw & report_gate;
    short_report_d = short_fault_raw & report_gate;

    // below 1/16 of full scale the small transistor is more accurate
    small_fet_d = brightness_source_config_d[ldcfg_pkg::LDCFG_SMALL_FET_BIT] &&
                  (current_setting < ldcfg_pkg::LDCFG_SMALL_FET_LIMIT);

    // steady dither widens dithering beyond slopes
    if (brightness_sloping || aux_config_d[ldcfg_pkg::LDCFG_STEADY_BIT])
    begin
      dither_act_d = cfg_d.dither_depth;
    end
    else
    begin
      dither_act_d = 3'd0;
    end

    // pin pass-through only in the direct mode, low otherwise
    pwm_pass_d = (cfg_d.brightness_source_select == ldcfg_pkg::LDCFG_BRT_PASS) &&
                 pwm_sync_q;
  end

  // outputs straight from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg                     <= '0;
      open_fault_report       <= 4'h0;
      short_fault_report      <= 4'h0;
      small_transistor_active <= 1'b0;
      dither_depth_active     <= 3'd0;
      pwm_pass_out            <= 1'b0;
    end
    else
    begin
      cfg                     <= cfg_d;
      open_fault_report       <= open_report_d;
      short_fault_report      <= short_report_d;
      small_transistor_active <= small_fet_d;
      dither_depth_active     <= dither_act_d;
      pwm_pass_out            <= pwm_pass_d;
    end
  end

  // ---------------------------------------------------------------
  // read data and response
  // ---------------------------------------------------------------
  logic [31:0] rdata_d;

  // reading the next-state bytes forwards a write in the same cycle,
  // so a read right behind a write sees the new value
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_take)
    begin
      case (haddr[11:0])
        {2'b00, ldcfg_pkg::LDCFG_IDX_FAULT, 2'b00}:
          rdata_d = {24'h00_0000, fault_and_headroom_config_d};
        {2'b00, ldcfg_pkg::LDCFG_IDX_DIM, 2'b00}:
          rdata_d = {24'h00_0000, dimming_resolution_config_d};
        {2'b00, ldcfg_pkg::LDCFG_IDX_BRT, 2'b00}:
          rdata_d = {24'h00_0000, brightness_source_config_d};
        ldcfg_pkg::LDCFG_ADDR_AUX:
          rdata_d = {24'h00_0000, aux_config_d};
        ldcfg_pkg::LDCFG_ADDR_STATUS:
          rdata_d = {20'h0_0000, dither_depth_active, small_transistor_active,
                     short_fault_report, open_fault_report};
        default:
          rdata_d = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // zero wait states; the answer is always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : ldcfg_bank

//--- core/ldcfg_pkg.sv
/*
  constants, decoding tables and carrier types of the led driver dimming
  configuration bank.
  assumes a 32-bit ahb-lite register bus and a 50 mhz system clock.
*/
package ldcfg_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index) and two direct byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  LDCFG_IDX_FAULT    = 8'h64;  // fault_and_headroom_config
  localparam logic [7:0]  LDCFG_IDX_DIM      = 8'h65;  // dimming_resolution_config
  localparam logic [7:0]  LDCFG_IDX_BRT      = 8'h66;  // brightness_source_config
  localparam logic [11:0] LDCFG_ADDR_AUX     = 12'h200; // scale and steady dither
  localparam logic [11:0] LDCFG_ADDR_STATUS  = 12'h204; // read-only block state

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LDCFG_CL_FAULT_BIT  = 7;   // cluster_fault_enable
  localparam int LDCFG_GAP_LSB       = 5;   // sink_comparator_gap [6:5]
  localparam int LDCFG_SHORT_LSB     = 3;   // short_detect_level [4:3]
  localparam int LDCFG_HEAD_LSB      = 0;   // sink_headroom_select [2:0]
  localparam int LDCFG_SLOPE_LSB     = 5;   // slope gain [7:5]
  localparam int LDCFG_RES_LSB       = 3;   // pwm resolution [4:3]
  localparam int LDCFG_DITHER_LSB    = 0;   // dither [2:0]
  localparam int LDCFG_RSVD_BIT      = 7;   // reserved, reads zero
  localparam int LDCFG_SWITCH_LSB    = 4;   // switch point [6:4]
  localparam int LDCFG_EXT_SET_BIT   = 3;   // external_set_resistor_enable
  localparam int LDCFG_SMALL_FET_BIT = 2;   // small_transistor_enable
  localparam int LDCFG_BRT_LSB       = 0;   // brightness_source_select [1:0]
  localparam int LDCFG_SCALE_LSB     = 0;   // max_current_scale [2:0] in aux
  localparam int LDCFG_STEADY_BIT    = 3;   // steady dither enable in aux

  // ---------------------------------------------------------------
  // reset values and thresholds
  // ---------------------------------------------------------------
  localparam logic [7:0]  LDCFG_RST_FAULT  = 8'h00;
  localparam logic [7:0]  LDCFG_RST_DIM    = 8'h00;
  localparam logic [7:0]  LDCFG_RST_BRT    = 8'h00;
  localparam logic [7:0]  LDCFG_RST_AUX    = 8'h00;
  localparam logic [11:0] LDCFG_SMALL_FET_LIMIT = 12'h100; // 1/16 of 4096

  // ---------------------------------------------------------------
  // decode tables, highest element (7, or 3 in the four-entry tables) written first
  // ---------------------------------------------------------------
  localparam logic [3:0][10:0] LDCFG_GAP_MV = {11'd250, 11'd500, 11'd750, 11'd1000};
  localparam logic [3:0][6:0]  LDCFG_SHORT_DV = {7'd106, 7'd69, 7'd36, 7'd36};
  localparam logic [7:0][10:0] LDCFG_HEAD_MV =
    {11'd50, 11'd175, 11'd300, 11'd450, 11'd575, 11'd700, 11'd875, 11'd1000};
  localparam logic [7:0][10:0] LDCFG_SLOPE_MILLI =
    {11'd1164, 11'd1141, 11'd1117, 11'd1094, 11'd1070, 11'd1047, 11'd1023, 11'd1000};
  localparam logic [3:0][5:0]  LDCFG_PWM_MHZ = {6'd40, 6'd20, 6'd10, 6'd5};
  localparam logic [7:0][8:0]  LDCFG_SWITCH_PERMILLE =
    {9'd125, 9'd156, 9'd188, 9'd219, 9'd250, 9'd313, 9'd406, 9'd500};
  localparam logic [7:0][7:0]  LDCFG_CUR_MA =
    {8'd150, 8'd120, 8'd100, 8'd80, 8'd60, 8'd50, 8'd30, 8'd25};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LDCFG_BRT_DUTY,
    LDCFG_BRT_PRODUCT,
    LDCFG_BRT_REGISTER,
    LDCFG_BRT_PASS
  } ldcfg_brt_t;

  // decoded configuration presented to dimming, boost and fault logic
  typedef struct packed
  {
    logic        cluster_fault_enable;
    logic [10:0] gap_mv;
    logic [6:0]  short_level_dv;     // tenths of a volt
    logic [10:0] headroom_mv;
    logic [10:0] slope_gain_milli;
    logic [5:0]  pwm_clock_mhz;
    logic [2:0]  dither_depth;       // 0 to 4 bits, as selected
    logic [8:0]  switch_permille;
    logic        external_set_resistor_enable;
    logic [7:0]  max_current_ma;
    ldcfg_brt_t  brightness_source_select;
  } ldcfg_decoded_t;

endpackage : ldcfg_pkg

//--- verification/ldcfg_bank_sva.sv
/*
  checker for the led driver dimming configuration bank: bus answer,
  fault gating, dither gating, pass-through and field decode.
  assumes one hclk domain and binding onto ldcfg_bank.
*/
`timescale 1ns/1ps
module ldcfg_bank_sva
(
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [3:0]            cluster_string,
  input wire logic [3:0]            open_fault_raw,
  input wire logic [3:0]            short_fault_raw,
  input wire logic                  brightness_sloping,
  input wire logic                  pwm_in_pin,
  input ldcfg_pkg::ldcfg_decoded_t  cfg,
  input wire logic [3:0]            open_fault_report,
  input wire logic [3:0]            short_fault_report,
  input wire logic [2:0]            dither_depth_active,
  input wire logic                  pwm_pass_out
);
  // ---------------------------------------------------------------
  // clocking and sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // read address phase of one word, then its data phase
  sequence rd_at(a);
    hsel && htrans[1] && !hwrite && haddr[11:0] == a ##1 1'b1;
  endsequence

  // source held on pass-through long enough to cover the synchroniser
  sequence src_pass;
    (cfg.brightness_source_select == ldcfg_pkg::LDCFG_BRT_PASS) [*4];
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // guard on stable cfg so either register or next-state sourcing passes
  a_open_gate: assert property ($past(hresetn) && $stable(cfg) |->
    open_fault_report == ($past(open_fault_raw) &
    (~$past(cluster_string) | {4{cfg.cluster_fault_enable}})))
    else $error("open fault report not gated by cluster enable");
  a_short_gate: assert property ($past(hresetn) && $stable(cfg) |->
    short_fault_report == ($past(short_fault_raw) &
    (~$past(cluster_string) | {4{cfg.cluster_fault_enable}})))
    else $error("short fault report not gated by cluster enable");
  a_dither_slope: assert property ($past(hresetn) && $past(brightness_sloping)
    && $stable(cfg) |-> dither_depth_active == cfg.dither_depth)
    else $error("dither not applied while sloping");
  a_ext_current: assert property (cfg.external_set_resistor_enable |->
    cfg.max_current_ma == 8'h00)
    else $error("stored scale used with set resistor enabled");
  a_pwm_pass: assert property (src_pass |-> pwm_pass_out == $past(pwm_in_pin, 3))
    else $error("pass-through output does not follow the pin");
  a_gap_decode: assert property (rd_at(12'h190) |->
    cfg.gap_mv == 11'd1000 - 11'd250 * hrdata[6:5])
    else $error("comparator gap does not match stored code");
  a_clock_decode: assert property (rd_at(12'h194) |->
    cfg.pwm_clock_mhz == (6'h05 << hrdata[4:3]))
    else $error("generator clock does not match stored code");
  a_rsvd_zero: assert property (rd_at(12'h198) |-> hrdata[31:7] == 25'h0)
    else $error("reserved bit of third register not zero");
endmodule : ldcfg_bank_sva

bind ldcfg_bank ldcfg_bank_sva i_sva
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cluster_string(cluster_string), .open_fault_raw(open_fault_raw),
  .short_fault_raw(short_fault_raw), .brightness_sloping(brightness_sloping),
  .pwm_in_pin(pwm_in_pin), .cfg(cfg), .open_fault_report(open_fault_report),
  .short_fault_report(short_fault_report), .dither_depth_active(dither_depth_active),
  .pwm_pass_out(pwm_pass_out)
);

//--- verification/tb_top.sv
/*
  self-checking bench: byte model of the configuration bank, ahb-lite
  master tasks and random side inputs, compared at every result.
  assumes a zero-wait slave and a 50 mhz hclk.
*/
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic                      hclk = 1'b0;
  logic                      hresetn = 1'b0;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [31:0]               hwdata = 32'h0;
  logic [31:0]               hrdata;
  logic                      hreadyout;
  logic                      hresp;
  logic [3:0]                cluster_string = 4'h0;
  logic [3:0]                open_fault_raw = 4'h0;
  logic [3:0]                short_fault_raw = 4'h0;
  logic [11:0]               current_setting = 12'h000;
  logic                      brightness_sloping = 1'b0;
  logic                      pwm_in_pin = 1'b0;
  ldcfg_pkg::ldcfg_decoded_t cfg;
  logic [3:0]                open_fault_report;
  logic [3:0]                short_fault_report;
  logic                      small_transistor_active;
  logic [2:0]                dither_depth_active;
  logic                      pwm_pass_out;
  logic [31:0]               d;
  int                        err_total = 0;
  int                        n_checks = 0;
  int                        i;
  int                        b[4];                                  // stored bytes
  int                        msk[4] = '{8'hff, 8'hff, 8'h7f, 8'h0f}; // writable bits
  logic [11:0]               ad[4] = '{12'h190, 12'h194, 12'h198, 12'h200};
  int                        head[8] = '{1000, 875, 700, 575, 450, 300, 175, 50};
  int                        slope[8] = '{1000, 1023, 1047, 1070, 1094, 1117, 1141, 1164};
  int                        swp[8] = '{500, 406, 313, 250, 219, 188, 156, 125};
  int                        cur[8] = '{25, 30, 50, 60, 80, 100, 120, 150};
  int                        shrt[4] = '{36, 36, 69, 106};

  // free-running 50 mhz clock
  always #10 hclk = ~hclk;

  ldcfg_bank i_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cluster_string(cluster_string), .open_fault_raw(open_fault_raw),
    .short_fault_raw(short_fault_raw), .current_setting(current_setting),
    .brightness_sloping(brightness_sloping), .pwm_in_pin(pwm_in_pin), .cfg(cfg),
    .open_fault_report(open_fault_report), .short_fault_report(short_fault_report),
    .small_transistor_active(small_transistor_active),
    .dither_depth_active(dither_depth_active), .pwm_pass_out(pwm_pass_out)
  );

  // ---------------------------------------------------------------
  // model decode and comparison
  // ---------------------------------------------------------------
  function automatic ldcfg_pkg::ldcfg_decoded_t dec();
    ldcfg_pkg::ldcfg_decoded_t e;
    e.cluster_fault_enable = b[0][7];
    e.gap_mv = 11'(1000 - 250 * ((b[0] >> 5) & 3));
    e.short_level_dv = 7'(shrt[(b[0] >> 3) & 3]);
    e.headroom_mv = 11'(head[b[0] & 7]);
    e.slope_gain_milli = 11'(slope[(b[1] >> 5) & 7]);
    e.pwm_clock_mhz = 6'(5 << ((b[1] >> 3) & 3));
    e.dither_depth = b[1][2] ? 3'h4 : 3'(b[1] & 3);   // any 1xx code is four bits
    e.switch_permille = 9'(swp[(b[2] >> 4) & 7]);
    e.external_set_resistor_enable = b[2][3];
    e.max_current_ma = b[2][3] ? 8'h00 : 8'(cur[b[3] & 7]);
    e.brightness_source_select = ldcfg_pkg::ldcfg_brt_t'(b[2] & 3);
    return e;
  endfunction : dec

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // ahb-lite master: one phase, bounded wait for hready
  // ---------------------------------------------------------------
  task automatic beat(output logic [31:0] rd);
    int   n;
    logic rdy;
    logic rsp;
    n = 0;
    // sample before the edge so read data is never raced by its update
    do
    begin
      @(negedge hclk);
      rd = hrdata;
      rdy = hreadyout;
      rsp = hresp;
      n++;
      @(posedge hclk);
    end
    while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t: bus wait expired", $time);
      results();
    end
    chk(128'(rsp), 128'h0);
  endtask : beat

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    beat(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    beat(d);
  endtask : xfer

  // random side inputs, held until the three-edge pin path has settled
  task automatic side();
    logic [3:0]  c, o, s;
    int          cs;
    logic        sl, p;
    logic [11:0] st;
    c = 4'($urandom);
    o = 4'($urandom);
    s = 4'($urandom);
    cs = $urandom_range(0, 511);
    sl = 1'($urandom);
    p = 1'($urandom);
    @(posedge hclk);
    cluster_string <= c;
    open_fault_raw <= o;
    short_fault_raw <= s;
    current_setting <= 12'(cs);
    brightness_sloping <= sl;
    pwm_in_pin <= p;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(128'(open_fault_report), 128'(o & (~c | {4{b[0][7]}})));
    chk(128'(short_fault_report), 128'(s & (~c | {4{b[0][7]}})));
    chk(128'(small_transistor_active), 128'(b[2][2] && cs < 256));
    chk(128'(dither_depth_active), 128'((sl || b[3][3]) ? dec().dither_depth : 3'h0));
    chk(128'(pwm_pass_out), 128'((b[2] & 3) == 3 && p));
    @(posedge hclk);
    // status word is read-only: a write there must leave the live flags alone
    xfer(1'b1, 12'h204, $urandom);
    xfer(1'b0, 12'h204, 32'h0);
    st = {3'((sl || b[3][3]) ? dec().dither_depth : 3'h0), b[2][2] && cs < 256,
          s & (~c | {4{b[0][7]}}), o & (~c | {4{b[0][7]}})};
    chk(128'(d), 128'(st));
  endtask : side

  // ---------------------------------------------------------------
  // main sequence: two resets, the second one in mid-run
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(96587));
    for (int k = 0; k < 2; k++)
    begin
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      b = '{0, 0, 0, 0};
      for (int j = 0; j < 4; j++)
      begin
        xfer(1'b0, ad[j], 32'h0);
        chk(128'(d), 128'h0);
      end
      for (int n = 0; n < 60; n++)
      begin
        i = $urandom_range(0, 4);
        // index four stands for an unmapped word, whose writes are dropped
        xfer(1'b1, (i < 4) ? ad[i] : 12'h1a0, $urandom);
        if (i < 4)
          b[i] = int'(hwdata) & msk[i];
        for (int j = 0; j < 5; j++)
        begin
          xfer(1'b0, (j < 4) ? ad[j] : 12'h1a0, 32'h0);
          chk(128'(d), 128'((j < 4) ? b[j] : 0));
        end
        @(negedge hclk);
        chk(128'(cfg), 128'(dec()));
        side();
      end
    end
    results();
  end
endmodule : tb_top
